// ### pkg/effecter_cmd_regs.vh
// register map, field codes, reset values and timing for the effecter commands
`ifndef EFFECTER_CMD_REGS_VH
`define EFFECTER_CMD_REGS_VH

// ==========================================================================
// register byte offsets
`define OFS_CMD 12'h000
`define OFS_HANDLE 12'h004
`define OFS_COUNT 12'h008
`define OFS_RESULT 12'h00C
`define OFS_CONFIG 12'h010
`define OFS_ENTRY_BASE 12'h020
`define OFS_RECORD_BASE 12'h040

// ==========================================================================
// field positions
`define CMD_SET_BIT 0
`define CMD_GET_BIT 1
`define CFG_MAXST_LSB 24

// ==========================================================================
// reserved handles and count limits
`define HANDLE_ZERO 16'h0000
`define HANDLE_ONES 16'hFFFF
`define COUNT_MIN 8'h01
`define COUNT_MAX 8'h08

// ==========================================================================
// result codes
`define RC_SUCCESS 8'h00
`define RC_BAD_DATA 8'h02
`define RC_BAD_HANDLE 8'h80
`define RC_BAD_STATE 8'h81
`define RC_ILLEGAL_COND 8'h82

// ==========================================================================
// change request and condition codes
`define CHG_LEAVE 8'h00
`define CHG_APPLY 8'h01
`define OPC_EN_UPD 8'h00
`define OPC_EN_NOUPD 8'h01
`define OPC_DISABLED 8'h02
`define STATE_UNKNOWN 8'h00

// ==========================================================================
// reset values
`define RST_HANDLE 16'h0001
`define RST_ENTRIES 8'h08
`define RST_MAXST 8'h04

// ==========================================================================
// settle time of an effecter after a state change
`define SETTLE_NS 100
`define CLK_NS 10
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### src/effecter_cmd.v
// state-effecter set/read command handler with an apb register port
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "effecter_cmd_regs.vh"

module effecter_cmd #(
  parameter ENTRIES = 8,
  parameter SETTLE = `SETTLE_CYC
) (
  input wire CLK, // 100 MHz clock
  input wire RST_N, // synchronous reset, active low
  input wire PSEL, // apb select
  input wire PENABLE, // apb access phase
  input wire PWRITE, // apb direction
  input wire [11:0] PADDR, // apb byte address
  input wire [31:0] PWDATA, // apb write data
  output reg [31:0] PRDATA, // apb read data
  output reg PREADY, // apb ready
  output reg PSLVERR, // apb error for unmapped address
  output reg [8*ENTRIES-1:0] EFFECTER_STATE // present state per entry
);

  // ========================================================================
  // configuration and request registers
  reg [15:0] handle_q; // request handle
  reg [7:0] count_q; // request entry count
  reg [7:0] result_q; // last result code
  reg [7:0] rcount_q; // count returned by read
  reg [15:0] cfg_handle_q; // implemented handle
  reg [7:0] cfg_entries_q; // implemented entries
  reg [7:0] cfg_maxst_q; // highest legal state code
  reg [7:0] chg_q [0:ENTRIES-1];
  reg [7:0] tgt_q [0:ENTRIES-1];
  reg [7:0] opc_q [0:ENTRIES-1];
  reg [7:0] prog_q [0:ENTRIES-1];
  reg [7:0] cur_q [0:ENTRIES-1];
  reg [15:0] tmr_q [0:ENTRIES-1];

  // ========================================================================
  // bus decode
  wire acc = PSEL & PENABLE;
  wire wr_now = acc & PREADY & PWRITE; // write lands with the handshake
  wire [2:0] idx = PADDR[4:2];
  // page bits widened to the 12-bit offset and index to 32 bits so no bits are dropped
  wire in_entry = ({5'h00, PADDR[11:5]} == (`OFS_ENTRY_BASE >> 5)) &&
                  ({29'h0, idx} < ENTRIES);
  wire in_record = ({5'h00, PADDR[11:5]} == (`OFS_RECORD_BASE >> 5)) &&
                   ({29'h0, idx} < ENTRIES);
  wire hit = (PADDR == `OFS_CMD) || (PADDR == `OFS_HANDLE) ||
             (PADDR == `OFS_COUNT) || (PADDR == `OFS_RESULT) ||
             (PADDR == `OFS_CONFIG) || in_entry || in_record;
  wire go_set = wr_now && (PADDR == `OFS_CMD) && PWDATA[`CMD_SET_BIT];
  wire go_get = wr_now && (PADDR == `OFS_CMD) && PWDATA[`CMD_GET_BIT];

  // ========================================================================
  // request checks, all done before anything is applied
  reg handle_bad;
  reg count_bad;
  reg cond_bad;
  reg state_bad;
  reg [7:0] set_rc;
  reg [7:0] get_rc;
  integer k;
  always @* begin
    handle_bad = (handle_q == `HANDLE_ZERO) || (handle_q == `HANDLE_ONES) ||
                 (handle_q != cfg_handle_q);
    count_bad = (count_q < `COUNT_MIN) || (count_q > `COUNT_MAX) ||
                (count_q > cfg_entries_q);
    cond_bad = 1'b0;
    state_bad = 1'b0;
    for (k = 0; k < ENTRIES; k = k + 1) begin
      if (k < count_q) begin
        if ((chg_q[k] != `CHG_LEAVE) && (chg_q[k] != `CHG_APPLY)) begin
          cond_bad = 1'b1;
        end
        if ((chg_q[k] == `CHG_APPLY) &&
            ((tgt_q[k] == `STATE_UNKNOWN) || (tgt_q[k] > cfg_maxst_q))) begin
          state_bad = 1'b1;
        end
      end
    end
    if (handle_bad) begin
      set_rc = `RC_BAD_HANDLE;
    end else if (count_bad) begin
      set_rc = `RC_BAD_DATA;
    end else if (cond_bad) begin
      set_rc = `RC_ILLEGAL_COND;
    end else if (state_bad) begin
      set_rc = `RC_BAD_STATE;
    end else begin
      set_rc = `RC_SUCCESS;
    end
    // read knows only the bad handle code
    get_rc = handle_bad ? `RC_BAD_HANDLE : `RC_SUCCESS;
  end

  // a single flag gates every entry update
  wire set_ok = go_set && (set_rc == `RC_SUCCESS);

  // ========================================================================
  // per-entry request, condition and state
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : ent
      wire en_cond = (opc_q[g] == `OPC_EN_UPD) ||
                     (opc_q[g] == `OPC_EN_NOUPD);
      wire wr_ent = wr_now && in_entry && (idx == g);
      wire wr_rec = wr_now && in_record && (idx == g);
      wire take = set_ok && (g < count_q) && (chg_q[g] == `CHG_APPLY) &&
                  en_cond;
      always @(posedge CLK) begin
        if (!RST_N) begin
          chg_q[g] <= `CHG_LEAVE;
          tgt_q[g] <= `STATE_UNKNOWN;
          opc_q[g] <= `OPC_EN_NOUPD;
          prog_q[g] <= `STATE_UNKNOWN;
          cur_q[g] <= `STATE_UNKNOWN;
          tmr_q[g] <= 16'h0000;
          EFFECTER_STATE[8*g+7:8*g] <= `STATE_UNKNOWN;
        end else begin
          // entry is change request plus target byte
          if (wr_ent) begin
            chg_q[g] <= PWDATA[7:0];
            tgt_q[g] <= PWDATA[15:8];
          end
          if (take) begin
            prog_q[g] <= tgt_q[g];
            opc_q[g] <= `OPC_EN_UPD;
            tmr_q[g] <= SETTLE[15:0];
          end else if (wr_rec) begin
            // condition set by software; disabling freezes state
            opc_q[g] <= PWDATA[7:0];
            tmr_q[g] <= 16'h0000;
          end else if (tmr_q[g] != 16'h0000) begin
            tmr_q[g] <= tmr_q[g] - 16'h0001;
            // a disabled effecter never reaches a new state
            if ((tmr_q[g] == 16'h0001) && (opc_q[g] == `OPC_EN_UPD)) begin
              cur_q[g] <= prog_q[g];
              EFFECTER_STATE[8*g+7:8*g] <= prog_q[g];
              opc_q[g] <= `OPC_EN_NOUPD;
            end
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // control registers and results
  always @(posedge CLK) begin
    if (!RST_N) begin
      handle_q <= `HANDLE_ZERO;
      count_q <= 8'h00;
      result_q <= `RC_SUCCESS;
      rcount_q <= 8'h00;
      cfg_handle_q <= `RST_HANDLE;
      cfg_entries_q <= `RST_ENTRIES;
      cfg_maxst_q <= `RST_MAXST;
    end else begin
      if (wr_now && (PADDR == `OFS_HANDLE)) begin
        handle_q <= PWDATA[15:0];
      end
      // count written by software before the set
      if (wr_now && (PADDR == `OFS_COUNT)) begin
        count_q <= PWDATA[7:0];
      end
      if (wr_now && (PADDR == `OFS_CONFIG)) begin
        cfg_handle_q <= PWDATA[15:0];
        cfg_entries_q <= PWDATA[23:16];
        cfg_maxst_q <= PWDATA[31:24];
      end
      // set wins over read when both bits are written together
      if (go_set) begin
        result_q <= set_rc;
      end else if (go_get) begin
        result_q <= get_rc;
        rcount_q <= handle_bad ? 8'h00 : cfg_entries_q;
      end
    end
  end

  // ========================================================================
  // read mux
  reg [31:0] rd;
  reg [7:0] r_opc;
  reg r_en;
  always @* begin
    r_opc = opc_q[idx];
    r_en = (r_opc == `OPC_EN_UPD) || (r_opc == `OPC_EN_NOUPD);
    rd = 32'h0000_0000;
    if (PADDR == `OFS_HANDLE) begin
      rd = {16'h0000, handle_q};
    end else if (PADDR == `OFS_COUNT) begin
      rd = {24'h00_0000, count_q};
    end else if (PADDR == `OFS_RESULT) begin
      rd = {16'h0000, rcount_q, result_q};
    end else if (PADDR == `OFS_CONFIG) begin
      rd = {cfg_maxst_q, cfg_entries_q, cfg_handle_q};
    end else if (in_entry) begin
      rd = {16'h0000, tgt_q[idx], chg_q[idx]};
    end else if (in_record) begin
      // condition and present state per record
      // states hidden unless an enabled condition
      rd = {8'h00,
            r_en ? cur_q[idx] : `STATE_UNKNOWN,
            r_en ? ((r_opc == `OPC_EN_UPD) ? prog_q[idx] : cur_q[idx])
                 : `STATE_UNKNOWN,
            r_opc};
    end
  end

  // ========================================================================
  // apb answer, one wait state so every output is registered
  always @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (acc && !PREADY) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? 32'h0000_0000 : rd;
      PSLVERR <= !hit;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### tb/effecter_cmd_properties.sv
// concurrent checks on the effecter command block ports
`timescale 1ns/1ps
`default_nettype none
`include "effecter_cmd_regs.vh"
module effecter_cmd_properties #(
  parameter ENTRIES = 8
) (
  input wire CLK, // clock
  input wire RST_N, // sync reset, active low
  input wire PSEL, // apb select
  input wire PENABLE, // apb access phase
  input wire PWRITE, // apb direction
  input wire [11:0] PADDR, // apb address
  input wire [31:0] PWDATA, // apb write data
  input wire [31:0] PRDATA, // apb read data
  input wire PREADY, // apb ready
  input wire PSLVERR, // apb error
  input wire [8*ENTRIES-1:0] EFFECTER_STATE // present states
);
  // ========================================================================
  // sequences and assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence access_s;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence set_cmd_s;
    PREADY && PWRITE && PADDR == `OFS_CMD && PWDATA[`CMD_SET_BIT];
  endsequence
  one_wait_a: assert property (access_s |=> PREADY)
    else $error("ready missing after access");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without request");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error outside ready");
  write_zero_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
    else $error("read data on write");
  unmapped_err_a: assert property (PREADY && PADDR == 12'h014 |-> PSLVERR)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (PREADY && PADDR < 12'h014 && PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("mapped address refused");
  // settle time keeps states still right after a set command
  settle_hold_a: assert property (set_cmd_s |=> $stable(EFFECTER_STATE)[*8])
    else $error("state moved before settling");
endmodule
bind effecter_cmd effecter_cmd_properties #(.ENTRIES(ENTRIES)) chk_u (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EFFECTER_STATE(EFFECTER_STATE));
`default_nettype wire

// ### tb/mgmt_master.sv
// apb master model standing in for the management controller
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
  input wire logic clk, // clock
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // slave error
  output logic psel = 1'b0, // select
  output logic penable = 1'b0, // access phase
  output logic pwrite = 1'b0, // direction
  output logic [11:0] paddr = 12'h000, // address
  output logic [31:0] pwdata = 32'h0 // write data
);
  // ========================================================================
  // one transfer, held until ready; released data is inverted, not kept
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb/state_effecter_set_get_cmds_tb_top.sv
// self-checking bench for the effecter command block
`timescale 1ns/1ps
`default_nettype none
`include "effecter_cmd_regs.vh"
module state_effecter_set_get_cmds_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [63:0] eff_state;
  int fails = 0;
  int total_checks = 0;
  // ========================================================================
  // clock, model and design
  always #5 clk = ~clk;
  mgmt_master master_u (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  effecter_cmd #(.ENTRIES(8), .SETTLE(10)) dut_u (.CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EFFECTER_STATE(eff_state));
  // ========================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    master_u.xfer(1'b1, a, d, rd_q, err_q);
  endtask
  task automatic rd(input logic [11:0] a);
    master_u.xfer(1'b0, a, 32'h0, rd_q, err_q);
  endtask
  // loads a two-entry set, starts it, checks the code, lets it settle
  task automatic do_set(input logic [15:0] h, input logic [7:0] c,
      input logic [31:0] e0, input logic [31:0] e1, input logic [7:0] rc);
    wr(`OFS_HANDLE, {16'h0, h});
    wr(`OFS_COUNT, {24'h0, c});
    wr(`OFS_ENTRY_BASE, e0);
    wr(`OFS_ENTRY_BASE + 12'h004, e1);
    wr(`OFS_CMD, 32'h1);
    rd(`OFS_RESULT);
    chk(rd_q, {24'h0, rc});
    repeat (12) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ========================================================================
  // scenarios
  task automatic t_reset;
    rd(`OFS_CONFIG);
    chk(rd_q, 32'h0408_0001);
    rd(`OFS_RECORD_BASE);
    chk(rd_q, 32'h0000_0001);
    rd(12'h014);
    chk({31'h0, err_q}, 32'h1);
  endtask
  task automatic t_set;
    do_set(16'h0001, 8'h02, 32'h0301, 32'h0200, `RC_SUCCESS);
    chk(eff_state[31:0], 32'h0000_0003);
    rd(`OFS_RECORD_BASE);
    chk(rd_q, 32'h0003_0301);
  endtask
  task automatic t_errors;
    do_set(16'h0000, 8'h01, 32'h0401, 32'h0, `RC_BAD_HANDLE);
    do_set(16'hFFFF, 8'h01, 32'h0401, 32'h0, `RC_BAD_HANDLE);
    do_set(16'h0002, 8'h01, 32'h0401, 32'h0, `RC_BAD_HANDLE);
    do_set(16'h0001, 8'h00, 32'h0401, 32'h0, `RC_BAD_DATA);
    do_set(16'h0001, 8'h09, 32'h0401, 32'h0, `RC_BAD_DATA);
    do_set(16'h0001, 8'h02, 32'h0401, 32'h02, `RC_ILLEGAL_COND);
    do_set(16'h0001, 8'h02, 32'h0401, 32'h0501, `RC_BAD_STATE);
    do_set(16'h0001, 8'h01, 32'h0001, 32'h0, `RC_BAD_STATE);
    chk(eff_state[31:0], 32'h0000_0003);
  endtask
  task automatic t_get;
    wr(`OFS_CMD, 32'h2);
    rd(`OFS_RESULT);
    chk(rd_q, 32'h0000_0800);
    wr(`OFS_HANDLE, 32'h0);
    wr(`OFS_CMD, 32'h2);
    rd(`OFS_RESULT);
    chk(rd_q, 32'h0000_0080);
  endtask
  task automatic t_disabled;
    wr(`OFS_RECORD_BASE + 12'h004, 32'h2);
    do_set(16'h0001, 8'h02, 32'h0, 32'h0401, `RC_SUCCESS);
    chk(eff_state[31:0], 32'h0000_0003);
    rd(`OFS_RECORD_BASE + 12'h004);
    chk(rd_q, 32'h0000_0002);
  endtask
  // ========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_set();
    t_errors();
    t_get();
    t_disabled();
    give_verdict();
  end
  // whole run needs well under this span
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
